// File: core/sec_engine.sv
// Behaviour
// [RULE1] commands arrive on data in at rising serial clock: start, opcode, address, data
// [RULE2] host ends each command with select low and keeps it low a deselect interval
// [RULE3] with select low the engine ignores clock and data and takes no command
// [RULE4] start bit is the first rising clock edge with data in high
// [RULE5] clock edges with data in low before the start bit are ignored
// [RULE6] in polling with output high, data in high at a clock edge starts a command
// [RULE7] host holds data in low while polling for completion
// [RULE8] read: after the last address bit the output drives low until the next edge
// [RULE9] then the addressed 16-bit word shifts out one bit per rising edge
// [RULE10] continued clocking after a word reads the next address without a new command
// [RULE11] sequential read address wraps from all ones to all zeros
// [RULE12] programming starts on select falling after the exact clock count
// [RULE13] while programming, clock and data are ignored and host sends nothing
// [RULE14] host starts commands only while the output is high or released
// [RULE15] the four programming commands act only in program-enable mode
// [RULE16] each programming cycle ends within 8 ms, typically 4 ms
// [RULE17] select raised after programming starts shows busy low or ready high
// [RULE18] host may hold select high or drop it and raise it later to poll
// [RULE19] every word holds all ones from delivery
// [RULE20] word erase sets all 16 bits at the address to one, no data bits
// [RULE21] enable and disable commands change the mode only at select falling
// [RULE22] programming commands with too many or too few clocks are cancelled
// [RULE23] at power application programming is cancelled and program-disable is set
// [RULE24] opcodes follow the usual three-wire 16-bit command set, 8 address bits
// [RULE25] output is released with select low and during command input
`timescale 1ns/1ns
`default_nettype none

module sec_engine #(
  parameter int unsigned P_PROG_CYCLES = sec_pkg::PROG_CYCLES
) (
  // core clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // serial link inputs
  input  wire logic i_serial_clock_in,
  input  wire logic i_chip_select,
  input  wire logic i_serial_data_in,
  // serial data output, enable low while driven
  output logic      o_serial_data_out,
  output logic      o_serial_data_out_oe_n
);
  import sec_pkg::*;

  localparam int unsigned SYNC_N = 4;

  // nonvolatile array, written only by the core domain
  logic [DATA_W-1:0] mem_q [0:WORDS-1];

  // link domain frame state
  logic              started_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic [SR_W-1:0]   sr_q;
  logic [SR_W-1:0]   sr_d;
  logic [HEAD_W-1:0] head_q;
  logic [HEAD_W-1:0] head_d;
  logic [CNT_W-1:0]  cnt_snap_q;
  logic [SR_W-1:0]   sr_snap_q;
  logic [HEAD_W-1:0] head_snap_q;

  // link domain read path
  logic              rd_hit;
  logic              rd_oe_q;
  logic              rd_do_q;
  logic [DATA_W-1:0] rd_sh_q;
  logic [3:0]        rd_idx_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic [ADDR_W-1:0] rd_next;

  // crossings into the core domain
  logic [SYNC_N-1:0] sync_in;
  logic [SYNC_N-1:0] sync_out;
  logic              sel_s;
  logic              start_s;
  logic              rd_oe_s;
  logic              rd_do_s;

  // core domain control
  sec_state_type     state_q;
  logic              sel_d_q;
  logic              sel_rise;
  logic              sel_fall;
  logic              ign_q;
  logic              frame_ok_q;
  logic              prog_en_q;
  logic              poll_q;
  logic              prog_done;
  logic              busy;
  logic              cmd_ok;
  logic              go;
  logic [1:0]        op;
  logic [1:0]        sub;
  logic              is_addr;
  logic              is_data;
  logic              p_write;
  logic              p_erase;
  logic              p_write_all_command;
  logic              p_erase_all_command;
  logic              m_en;
  logic              m_dis;
  logic              pend_all_q;
  logic [ADDR_W-1:0] pend_addr_q;
  logic [DATA_W-1:0] pend_data_q;

  // next frame values: nothing moves before the start bit
  always_comb
  begin
    cnt_d  = cnt_q;
    sr_d   = sr_q;
    head_d = head_q;
    if (started_q)
    begin
      if (cnt_q != CNT_MAX)
      begin
        cnt_d = cnt_q + CNT_ONE;
      end
      sr_d = {sr_q[SR_W-2:0], i_serial_data_in}; // [RULE1]
      if (cnt_q < CNT_HEAD)
      begin
        head_d = {head_q[HEAD_W-2:0], i_serial_data_in};
      end
    end
  end

  // start bit detection; select low holds the frame cleared
  always_ff @(posedge i_serial_clock_in or negedge i_chip_select)
  begin
    if (!i_chip_select)
    begin
      started_q <= 1'b0; // [RULE3]
    end
    else if (!started_q && i_serial_data_in)
    begin
      started_q <= 1'b1; // [RULE4] [RULE6]
    end
  end

  // frame shift and count; dummy clocks leave them untouched
  always_ff @(posedge i_serial_clock_in or negedge i_chip_select)
  begin
    if (!i_chip_select)
    begin
      cnt_q  <= '0;
      sr_q   <= '0;
      head_q <= '0;
    end
    else
    begin
      cnt_q  <= cnt_d; // [RULE5]
      sr_q   <= sr_d;
      head_q <= head_d;
    end
  end

  // snapshot survives select falling, so the core can read it afterwards
  always_ff @(posedge i_serial_clock_in)
  begin
    if (i_chip_select && started_q)
    begin
      cnt_snap_q  <= cnt_d;
      sr_snap_q   <= sr_d;
      head_snap_q <= head_d;
    end
  end

  // read fires on the edge that latches the last address bit
  assign rd_hit  = started_q && (cnt_q == CNT_ADDR_LAST)
                   && (head_q[OP_LSB_HEAD +: 2] == OP_READ);
  assign rd_next = rd_addr_q + ADDR_W'(1); // [RULE11]

  // read shifter; it also runs for a frame sent while programming, where busy status and ign_q keep its data off the pin
  always_ff @(posedge i_serial_clock_in or negedge i_chip_select)
  begin
    if (!i_chip_select)
    begin
      rd_oe_q   <= 1'b0;
      rd_do_q   <= 1'b0;
      rd_sh_q   <= '0;
      rd_idx_q  <= '0;
      rd_addr_q <= '0;
    end
    else if (rd_hit)
    begin
      rd_oe_q   <= 1'b1;
      rd_do_q   <= 1'b0; // [RULE8]
      rd_addr_q <= sr_d[ADDR_W-1:0];
      rd_sh_q   <= mem_q[sr_d[ADDR_W-1:0]];
      rd_idx_q  <= '0;
    end
    else if (rd_oe_q)
    begin
      rd_do_q  <= rd_sh_q[DATA_W-1]; // [RULE9]
      rd_idx_q <= rd_idx_q + 4'h1;
      if (rd_idx_q == 4'hf)
      begin
        rd_addr_q <= rd_next; // [RULE10]
        rd_sh_q   <= mem_q[rd_next];
      end
      else
      begin
        rd_sh_q <= {rd_sh_q[DATA_W-2:0], 1'b0};
      end
    end
  end

  // select, start, read enable and read data pass two flops into the core
  assign sync_in = {i_chip_select, started_q, rd_oe_q, rd_do_q};

  generate
    for (genvar g = 0; g < SYNC_N; g++)
    begin : g_sync
      sec_sync u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_d     (sync_in[g]),
        .o_q     (sync_out[g])
      );
    end
  endgenerate

  assign sel_s    = sync_out[3];
  assign start_s  = sync_out[2];
  assign rd_oe_s  = sync_out[1];
  assign rd_do_s  = sync_out[0];
  assign sel_rise = sel_s && !sel_d_q;
  assign sel_fall = !sel_s && sel_d_q;
  assign busy     = (state_q == ST_PROG);

  // select edge detect and frame qualification
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sel_d_q    <= 1'b0;
      ign_q      <= 1'b0;
      frame_ok_q <= 1'b0;
    end
    else
    begin
      sel_d_q <= sel_s;
      if (sel_rise)
      begin
        ign_q      <= 1'b0;
        frame_ok_q <= 1'b0;
      end
      else if (sel_s && start_s)
      begin
        frame_ok_q <= 1'b1;
        if (busy)
        begin
          ign_q <= 1'b1; // [RULE13]
        end
      end
    end
  end

  // decode of the finished frame
  assign op      = head_snap_q[OP_LSB_HEAD +: 2]; // [RULE24]
  assign sub     = head_snap_q[1:0];
  assign is_addr = (cnt_snap_q == CNT_ADDR);
  assign is_data = (cnt_snap_q == CNT_DATA);
  assign p_write = (op == OP_WRITE) && is_data; // [RULE22]
  assign p_erase = (op == OP_ERASE) && is_addr; // [RULE20] [RULE22]
  assign p_write_all_command  = (op == OP_EXT) && (sub == EXT_WRITE_ALL_COMMAND) && is_data;
  assign p_erase_all_command  = (op == OP_EXT) && (sub == EXT_ERASE_ALL_COMMAND) && is_addr;
  assign m_en    = (op == OP_EXT) && (sub == EXT_EN)
                   && (cnt_snap_q >= CNT_HEAD) && (cnt_snap_q <= CNT_ADDR);
  assign m_dis   = (op == OP_EXT) && (sub == EXT_DIS)
                   && (cnt_snap_q >= CNT_HEAD) && (cnt_snap_q <= CNT_ADDR);
  assign cmd_ok  = sel_fall && frame_ok_q && !ign_q && !busy; // [RULE2] [RULE3]
  assign go      = cmd_ok && prog_en_q
                   && (p_write || p_erase || p_write_all_command || p_erase_all_command); // [RULE12] [RULE15]

  // write permission; power-up leaves it disabled
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      prog_en_q <= PROG_EN_RST; // [RULE23]
    end
    else if (cmd_ok && m_en)
    begin
      prog_en_q <= 1'b1; // [RULE21]
    end
    else if (cmd_ok && m_dis)
    begin
      prog_en_q <= 1'b0; // [RULE21]
    end
  end

  // latch what the cycle will store; erase kinds store all ones
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      pend_all_q  <= 1'b0;
      pend_addr_q <= '0;
      pend_data_q <= WORD_ERASED;
    end
    else if (go)
    begin
      pend_all_q <= p_write_all_command || p_erase_all_command;
      if (p_write || p_write_all_command)
      begin
        pend_addr_q <= sr_snap_q[ADDR_LSB_LONG +: ADDR_W];
        pend_data_q <= sr_snap_q[DATA_LSB +: DATA_W];
      end
      else
      begin
        pend_addr_q <= sr_snap_q[ADDR_W-1:0];
        pend_data_q <= WORD_ERASED; // [RULE20]
      end
    end
  end

  // engine state
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= ST_IDLE; // [RULE23]
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (go)
          begin
            state_q <= ST_PROG;
          end
        end
        ST_PROG:
        begin
          if (prog_done)
          begin
            state_q <= ST_IDLE;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // self-timed cycle length
  sec_prog_timer #(
    .P_CYCLES (P_PROG_CYCLES)
  ) u_timer (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_start (go),
    .o_done  (prog_done) // [RULE16]
  );

  // array update at the end of the cycle; reset stands in for delivery
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < WORDS; i++)
      begin
        mem_q[i] <= WORD_ERASED; // [RULE19]
      end
    end
    else if (prog_done && busy)
    begin
      if (pend_all_q)
      begin
        for (int i = 0; i < WORDS; i++)
        begin
          mem_q[i] <= pend_data_q;
        end
      end
      else
      begin
        mem_q[pend_addr_q] <= pend_data_q;
      end
    end
  end

  // polling window lasts until a new start bit is seen after ready
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      poll_q <= 1'b0;
    end
    else if (go)
    begin
      poll_q <= 1'b1; // [RULE18]
    end
    else if (sel_s && start_s && !busy)
    begin
      poll_q <= 1'b0; // [RULE6]
    end
  end

  // output pin: status wins over read data, released otherwise
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_serial_data_out      <= 1'b0;
      o_serial_data_out_oe_n <= 1'b1;
    end
    else if (!sel_s)
    begin
      o_serial_data_out      <= 1'b0;
      o_serial_data_out_oe_n <= 1'b1; // [RULE25]
    end
    else if (busy)
    begin
      o_serial_data_out      <= 1'b0; // [RULE17]
      o_serial_data_out_oe_n <= 1'b0;
    end
    else if (poll_q && !start_s)
    begin
      o_serial_data_out      <= 1'b1; // [RULE17]
      o_serial_data_out_oe_n <= 1'b0;
    end
    else if (rd_oe_s && !ign_q)
    begin
      o_serial_data_out      <= rd_do_s; // [RULE8] [RULE9]
      o_serial_data_out_oe_n <= 1'b0;
    end
    else
    begin
      o_serial_data_out      <= 1'b0;
      o_serial_data_out_oe_n <= 1'b1; // [RULE25]
    end
  end

endmodule : sec_engine

`default_nettype wire

// File: core/sec_pkg.sv
`default_nettype none

package sec_pkg;

  // core clock
  localparam int unsigned CLK_PERIOD_NS = 8;

  // self-timed programming: typical cycle, well inside the 8 ms ceiling
  localparam int unsigned PROG_TIME_US = 4000;
  localparam int unsigned PROG_CYCLES  = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PROG_CNT_W   = 20;

  // array organisation
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned WORDS  = 256;

  // frame shift and count layout, counted in bits after the start bit
  localparam int unsigned CNT_W  = 6;
  localparam int unsigned SR_W   = 26;
  localparam int unsigned HEAD_W = 4;
  localparam logic [CNT_W-1:0] CNT_ONE       = 6'h01;
  localparam logic [CNT_W-1:0] CNT_HEAD      = 6'h04;
  localparam logic [CNT_W-1:0] CNT_ADDR      = 6'h0a;
  localparam logic [CNT_W-1:0] CNT_ADDR_LAST = 6'h09;
  localparam logic [CNT_W-1:0] CNT_DATA      = 6'h1a;
  localparam logic [CNT_W-1:0] CNT_MAX       = 6'h3f;

  // field positions inside the captured shift word
  localparam int unsigned DATA_LSB      = 0;
  localparam int unsigned ADDR_LSB_LONG = 16;
  localparam int unsigned OP_LSB_HEAD   = 2;

  // opcodes and extended sub-codes
  localparam logic [1:0] OP_EXT   = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_DIS  = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL_COMMAND = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL_COMMAND = 2'h2;
  localparam logic [1:0] EXT_EN   = 2'h3;

  // values after reset
  localparam logic [DATA_W-1:0] WORD_ERASED = 16'hffff;
  localparam logic              PROG_EN_RST = 1'b0;

  // engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PROG = 2'b10
  } sec_state_type;

endpackage : sec_pkg

`default_nettype wire

// File: core/sec_prog_timer.sv
`timescale 1ns/1ns
`default_nettype none

module sec_prog_timer #(
  parameter int unsigned P_CYCLES = sec_pkg::PROG_CYCLES
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // start pulse and completion pulse
  input  wire logic i_start,
  output logic      o_done
);
  import sec_pkg::*;

  localparam logic [PROG_CNT_W-1:0] LOAD = PROG_CNT_W'(P_CYCLES - 1);

  logic [PROG_CNT_W-1:0] cnt_q;
  logic                  run_q;

  // down counter, one done pulse per start
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start)
      begin
        run_q <= 1'b1;
        cnt_q <= LOAD;
      end
      else if (run_q)
      begin
        if (cnt_q == '0)
        begin
          run_q  <= 1'b0;
          o_done <= 1'b1;
        end
        else
        begin
          cnt_q <= cnt_q - PROG_CNT_W'(1);
        end
      end
    end
  end

endmodule : sec_prog_timer

`default_nettype wire

// File: core/sec_sync.sv
`timescale 1ns/1ns
`default_nettype none

module sec_sync (
  // destination clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // level from another domain
  input  wire logic i_d,
  output logic      o_q
);

  logic meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      meta_q <= 1'b0;
      o_q    <= 1'b0;
    end
    else
    begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end

endmodule : sec_sync

`default_nettype wire

// File: tb/sec_engine_props.sv
`timescale 1ns/1ns
`default_nettype none

module sec_engine_props #(
  parameter int unsigned P_PROG_CYCLES = 50
) (
  // core clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // link pins as seen at the engine
  input wire logic i_serial_clock_in,
  input wire logic i_chip_select,
  input wire logic i_serial_data_in,
  input wire logic o_serial_data_out,
  input wire logic o_serial_data_out_oe_n
);
  localparam int unsigned BUSY_MAX = P_PROG_CYCLES + 16;
  logic [6:0]  sclk_q;
  logic        sclk_recent;
  int unsigned busy_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // coarse serial clock history; the link is asynchronous so only a window is trusted
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      sclk_q <= '0;
    else
      sclk_q <= {sclk_q[5:0], i_serial_clock_in};
  end
  assign sclk_recent = |(sclk_q[5:0] & ~sclk_q[6:1]);

  // length of a driven low level with select high and the serial clock still
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || !i_chip_select || o_serial_data_out_oe_n || o_serial_data_out
        || sclk_recent)
      busy_q <= 0;
    else
      busy_q <= busy_q + 1;
  end

  release_deselect_a: assert property (!i_chip_select [*5] |-> o_serial_data_out_oe_n)
    else $error("output driven with select low");
  reset_quiet_a: assert property ($rose(i_rst_n) |-> o_serial_data_out_oe_n)
    else $error("output driven right after reset");
  drive_select_a: assert property ($fell(o_serial_data_out_oe_n) |-> $past(i_chip_select, 2))
    else $error("output driven without select");
  fall_clock_a: assert property ($fell(o_serial_data_out) && !o_serial_data_out_oe_n
    && !$past(o_serial_data_out_oe_n) |-> sclk_recent) else $error("data changed without clock");
  lead_low_a: assert property ($fell(o_serial_data_out_oe_n) && sclk_recent
    |-> !o_serial_data_out) else $error("read did not open low");
  restart_bit_a: assert property (!o_serial_data_out_oe_n && o_serial_data_out
    && i_chip_select && i_serial_data_in && sclk_q[0] && !sclk_q[1]
    |-> ##[1:10] o_serial_data_out_oe_n) else $error("start bit after ready not taken");
  release_cause_a: assert property ($rose(o_serial_data_out_oe_n) && i_chip_select
    && $past(i_chip_select, 6) |-> sclk_recent) else $error("released without clock");
  prog_bound_a: assert property (busy_q <= BUSY_MAX)
    else $error("busy status held too long");

  cover property ($fell(o_serial_data_out_oe_n) && sclk_recent);
  cover property (i_chip_select && !o_serial_data_out_oe_n && o_serial_data_out && !sclk_recent);
  cover property (busy_q == 20);
endmodule : sec_engine_props

bind sec_engine sec_engine_props #(.P_PROG_CYCLES(P_PROG_CYCLES)) u_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_serial_clock_in(i_serial_clock_in),
  .i_chip_select(i_chip_select), .i_serial_data_in(i_serial_data_in),
  .o_serial_data_out(o_serial_data_out), .o_serial_data_out_oe_n(o_serial_data_out_oe_n));

`default_nettype wire

// File: tb/sec_engine_tb.sv
`timescale 1ns/1ns
`default_nettype none

module sec_engine_tb;
  import sec_pkg::*;
  localparam int unsigned PROG = 50;
  logic clk    = 1'b0;
  logic rst_n  = 1'b0;
  logic last_q = 1'b0;
  logic cs, sclk, sdi, dout, oe_n, line;
  int   errors = 0;
  int   total_checks = 0;

  always #4 clk = ~clk;
  // a released line shows the inverse of its last level, so a stale bit never passes
  always @(posedge clk)
    if (!oe_n)
      last_q <= dout;
  assign line = oe_n ? ~last_q : dout;

  sec_engine #(.P_PROG_CYCLES(PROG)) dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_serial_clock_in(sclk), .i_chip_select(cs),
    .i_serial_data_in(sdi), .o_serial_data_out(dout), .o_serial_data_out_oe_n(oe_n));
  sec_host_model host (.i_line(line), .o_chip_select(cs), .o_serial_clock(sclk),
    .o_serial_data(sdi));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic send(input logic [31:0] bits, input int n);
    logic [47:0] rx;
    host.xfer(bits, n, 0, rx);
  endtask : send

  // programming command; busy first, then ready inside the bound before anything else
  task automatic prog(input logic [31:0] bits, input int n);
    int   waited;
    logic first;
    send(bits, n);
    host.poll(PROG + 40, waited, first);
    check("busy status", 0, first);
    check("ready in time", 1, waited < PROG + 40);
  endtask : prog

  task automatic rd2(input logic [7:0] a, input logic [31:0] exp, input int dummy);
    logic [47:0] rx;
    host.xfer({21'h0, 1'b1, OP_READ, a}, 11 + dummy, 32, rx);
    check("lead low", 0, rx[32]);
    check("read words", exp, rx[31:0]);
  endtask : rd2

  task automatic t_locked;
    rd2(8'hff, 32'hffffffff, 5);
    send({5'h0, 1'b1, OP_WRITE, 8'h10, 16'h1234}, 27);
    rd2(8'h10, 32'hffffffff, 0);
  endtask : t_locked

  // enable with and without address bits, writes at both ends, read across the wrap
  task automatic t_write;
    send({21'h0, 1'b1, OP_EXT, EXT_EN, 6'h00}, 11);
    prog({5'h0, 1'b1, OP_WRITE, 8'hff, 16'h1234}, 27);
    send({27'h0, 1'b1, OP_EXT, EXT_EN}, 5);
    prog({5'h0, 1'b1, OP_WRITE, 8'h00, 16'habcd}, 27);
    rd2(8'hff, 32'h1234abcd, 0);
  endtask : t_write

  // one clock too many or too few cancels the command
  task automatic t_count;
    send({4'h0, 1'b1, OP_WRITE, 8'hff, 16'h5555, 1'b0}, 28);
    send({6'h0, 1'b1, OP_WRITE, 8'hff, 15'h2aaa}, 26);
    send({20'h0, 1'b1, OP_ERASE, 8'h00, 1'b0}, 12);
    rd2(8'hff, 32'h1234abcd, 0);
  endtask : t_count

  task automatic t_erase_all;
    prog({21'h0, 1'b1, OP_ERASE, 8'hff}, 11);
    rd2(8'hff, 32'hffffabcd, 3);
    prog({5'h0, 1'b1, OP_EXT, EXT_WRITE_ALL_COMMAND, 6'h00, 16'h5a5a}, 27);
    rd2(8'h80, 32'h5a5a5a5a, 0);
    prog({21'h0, 1'b1, OP_EXT, EXT_ERASE_ALL_COMMAND, 6'h00}, 11);
    rd2(8'h80, 32'hffffffff, 0);
  endtask : t_erase_all

  // a frame whose start bit lands while programming runs is dropped whole
  task automatic t_busy;
    send({5'h0, 1'b1, OP_WRITE, 8'h40, 16'h0a0a}, 27);
    send({5'h0, 1'b1, OP_WRITE, 8'h41, 16'h0b0b}, 27);
    rd2(8'h40, 32'h0a0affff, 0);
  endtask : t_busy

  // disable blocks writing; deselected activity is ignored
  task automatic t_disable;
    send({27'h0, 1'b1, OP_EXT, EXT_DIS}, 5);
    send({5'h0, 1'b1, OP_WRITE, 8'h20, 16'h0f0f}, 27);
    host.noise(12);
    check("released", 1, oe_n);
    rd2(8'h20, 32'hffffffff, 0);
  endtask : t_disable

  task automatic t_reset;
    send({27'h0, 1'b1, OP_EXT, EXT_EN}, 5);
    prog({5'h0, 1'b1, OP_WRITE, 8'h30, 16'h0001}, 27);
    rd2(8'h30, 32'h0001ffff, 0);
    @(negedge clk) rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    #3;
    rd2(8'h30, 32'hffffffff, 0);
    send({5'h0, 1'b1, OP_WRITE, 8'h30, 16'h0001}, 27);
    rd2(8'h30, 32'hffffffff, 0);
  endtask : t_reset

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // main sequence; the offset keeps link edges away from core edges
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    #3;
    t_locked();
    t_write();
    t_count();
    t_erase_all();
    t_busy();
    t_disable();
    t_reset();
    close_out();
  end

  // a hung run is cut short here
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    close_out();
  end
endmodule : sec_engine_tb

`default_nettype wire

// File: tb/sec_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module sec_host_model (
  // resolved data line
  input  wire logic i_line,
  // host drives
  output var logic  o_chip_select,
  output var logic  o_serial_clock,
  output var logic  o_serial_data
);
  // everything idle low; outside frames the clock moves only in noise
  initial
  begin
    o_chip_select  = 1'b0;
    o_serial_clock = 1'b0;
    o_serial_data  = 1'b0;
  end

  // one frame, msb first, then rd clocks with data low; each edge is answered late in the
  // period, so the line is sampled just before the next rise
  task automatic xfer(input logic [31:0] bits, input int n, input int rd, output logic [47:0] rx);
    rx = '0;
    o_chip_select = 1'b1;
    #64;
    for (int i = 0; i < n + rd; i++)
    begin
      o_serial_data = (i < n) ? bits[n-1-i] : 1'b0;
      #14 if (i > 0) rx = {rx[46:0], i_line};
      #2 o_serial_clock = 1'b1;
      #16 o_serial_clock = 1'b0;
    end
    o_serial_data = 1'b0;
    #14 rx = {rx[46:0], i_line};
    o_chip_select = 1'b0;
    #64;
  endtask : xfer

  // select high with the clock still until the line reads high, bounded
  task automatic poll(input int lim, output int waited, output logic first);
    o_chip_select = 1'b1;
    #40 first = i_line;
    waited = 0;
    while (i_line !== 1'b1 && waited < lim)
    begin
      #8 waited++;
    end
    o_chip_select = 1'b0;
    #64;
  endtask : poll

  // clock and data activity while deselected
  task automatic noise(input int n);
    repeat (n)
    begin
      o_serial_data = 1'b1;
      #16 o_serial_clock = 1'b1;
      #16 o_serial_clock = 1'b0;
    end
    o_serial_data = 1'b0;
  endtask : noise
endmodule : sec_host_model

`default_nettype wire
